// ==== event_select_pkg.sv ====
// constants, types and register map for the branch, dispatch and stall event selector
package event_select_pkg;

    // ==========================================================
    // event numbers
    localparam logic [7:0] EVT_EXECUTED_BRANCH    = 8'h88;
    localparam logic [7:0] EVT_MISPREDICTED_BRANCH = 8'h89;
    localparam logic [7:0] EVT_UNDELIVERED_UOP    = 8'h9c;
    localparam logic [7:0] EVT_PORT_DISPATCH      = 8'ha1;
    localparam logic [7:0] EVT_RESOURCE_STALL     = 8'ha2;

    // ==========================================================
    // branch qualifier bits
    localparam logic [7:0] Q_COND          = 8'h01;
    localparam logic [7:0] Q_DIRECT_JMP    = 8'h02;
    localparam logic [7:0] Q_INDIRECT_JMP  = 8'h04;
    localparam logic [7:0] Q_RETURN        = 8'h08;
    localparam logic [7:0] Q_DIRECT_CALL   = 8'h10;
    localparam logic [7:0] Q_INDIRECT_CALL = 8'h20;
    localparam logic [7:0] Q_NOT_TAKEN     = 8'h40;
    localparam logic [7:0] Q_TAKEN         = 8'h80;
    localparam logic [7:0] Q_ALL_BRANCHES  = 8'hff;
    localparam logic [7:0] Q_TYPE_MASK     = 8'h3f;
    localparam logic [7:0] Q_NONE          = 8'h00;

    // ==========================================================
    // undelivered uop qualifier
    localparam logic [7:0] Q_UNDELIVERED_CORE = 8'h01;

    // ==========================================================
    // port dispatch qualifiers
    localparam logic [7:0] Q_PORT_0      = 8'h01;
    localparam logic [7:0] Q_PORT_1      = 8'h02;
    localparam logic [7:0] Q_PORT_2_LD   = 8'h04;
    localparam logic [7:0] Q_PORT_2_STA  = 8'h08;
    localparam logic [7:0] Q_PORT_2_ANY  = 8'h0c;
    localparam logic [7:0] Q_PORT_3_LD   = 8'h10;
    localparam logic [7:0] Q_PORT_3_STA  = 8'h20;
    localparam logic [7:0] Q_PORT_3_ANY  = 8'h30;
    localparam logic [7:0] Q_PORT_4      = 8'h40;
    localparam logic [7:0] Q_PORT_5      = 8'h80;

    // ==========================================================
    // resource stall qualifiers
    localparam logic [7:0] Q_STALL_ANY   = 8'h01;
    localparam logic [7:0] Q_STALL_LOAD  = 8'h02;
    localparam logic [7:0] Q_STALL_RS    = 8'h04;
    localparam logic [7:0] Q_STALL_STORE = 8'h08;
    localparam logic [7:0] Q_STALL_ROB   = 8'h10;
    localparam logic [7:0] Q_STALL_FPCW  = 8'h20;
    localparam logic [7:0] Q_STALL_SIMD  = 8'h40;

    // ==========================================================
    // register map (byte addresses, one word each)
    localparam int           ADR_W          = 4;
    localparam logic [3:0]   OFS_SELECT     = 4'h0;
    localparam logic [3:0]   OFS_STATUS     = 4'h4;
    localparam logic [3:0]   OFS_TALLY      = 4'h8;
    localparam logic [7:0]   RST_EVENT      = 8'h00;
    localparam logic [7:0]   RST_QUAL       = 8'h00;
    localparam logic [31:0]  RST_TALLY      = 32'h0000_0000;
    localparam int           SEL_EVENT_LSB  = 0;
    localparam int           SEL_QUAL_LSB   = 8;
    localparam int           STAT_VALID_BIT = 0;
    localparam int           STAT_INC_LSB   = 4;
    localparam int           INC_W          = 3;
    localparam logic [2:0]   INC_ZERO       = 3'h0;
    localparam logic [2:0]   INC_ONE        = 3'h1;

    // ==========================================================
    // pipeline status carried in from the core
    typedef struct packed {
        logic       valid;       // a near branch executed this cycle
        logic [5:0] kind;        // one-hot, same order as qualifier bits 0..5
        logic       taken;
        logic       mispredicted;
    } branch_status_t;

    typedef struct packed {
        logic p0;
        logic p1;
        logic p2_load;
        logic p2_sta;
        logic p3_load;
        logic p3_sta;
        logic p4;
        logic p5;
    } dispatch_status_t;

    typedef struct packed {
        logic any;
        logic load_buf;
        logic resv_station;
        logic store_buf;
        logic store_sync_drain;
        logic reorder_buffer;
        logic fp_control_word;
        logic simd_control_status_reg;
    } stall_status_t;

    typedef struct packed {
        branch_status_t   branch;
        logic [2:0]       undelivered_uops;  // per thread, to rename_stage
        dispatch_status_t dispatch;
        stall_status_t    stall;
    } core_status_t;

endpackage

// ==== branch_dispatch_stall_event_select.sv ====
// per-cycle increment selector for branch, dispatch and allocation stall events
// What this block does
// - 88H/10H counts executed direct near calls; needs taken qualifier 80H.
// - 88H/20H counts executed register or memory indirect near calls; needs 80H.
// - 88H/40H selects not-taken executed branches; only with conditional 01H.
// - 88H/80H selects taken executed branches; needs a type bit 01H..20H.
// - qualifier FFH on 88H or 89H counts every executed near branch.
// - 89H/01H counts mispredicted conditional branches; needs 40H or 80H.
// - 89H/04H mispredicted indirect jumps, 08H mispredicted returns; need 80H.
// - 89H/10H mispredicted direct calls, 20H mispredicted indirect calls; need 80H.
// - 89H/40H selects mispredicted not-taken branches; only with 01H.
// - 89H/80H selects mispredicted taken branches; needs a type bit.
// - 9CH/01H adds the per-thread count of undelivered uops each cycle.
// - A1H counts port 0 dispatch cycles with 01H, port 1 with 02H.
// - A1H port 2: loads 04H, store-address 08H, any uop 0CH.
// - A1H port 3: loads 10H, store-address 20H, any uop 30H.
// - A1H counts port 4 dispatch cycles with 40H, port 5 with 80H.
// - A2H/01H counts cycles allocation stalls for any resource reason.
// - A2H/02H counts stalls for no free load buffer.
// - A2H/04H counts stalls for no eligible reservation station entry.
// - A2H/08H counts store buffer stalls, excluding sync draining.
// - A2H/10H counts stalls for a full reorder buffer.
// - A2H/20H counts stalls from writing the fp control word.
// - A2H/40H counts stalls from too-close simd control/status renames.
`timescale 1ns/1ps

module branch_dispatch_stall_event_select
    import event_select_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // classic wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [ADR_W-1:0]     adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    // pipeline status
    input  wire core_status_t         core_status_i,
    // selected increment for the counter
    output logic      [INC_W-1:0]     inc_o
);

    // ==========================================================
    // selection registers
    logic [7:0]        event_r;
    logic [7:0]        qual_r;
    logic [31:0]       tally_r;
    logic [INC_W-1:0]  inc_r;
    logic              ack_r;
    logic [31:0]       dat_r;
    logic              access;
    logic              sel_write;

    assign access    = cyc_i && stb_i && !ack_r;
    assign sel_write = access && we_i && (adr_i == OFS_SELECT);

    // ==========================================================
    // branch qualification, shared by executed and mispredicted events
    function automatic logic branch_qual_ok(input logic [7:0] q);
        logic [5:0] types;
        logic       bad;
        types = q[5:0] & Q_TYPE_MASK[5:0];
        bad   = 1'b0;
        if (q == Q_ALL_BRANCHES) begin
            bad = 1'b0;
        end else begin
            if (types == 6'h00) begin
                bad = 1'b1;
            end
            if ((q & (Q_TAKEN | Q_NOT_TAKEN)) == Q_NONE) begin
                bad = 1'b1;
            end
            if ((q & Q_NOT_TAKEN) != Q_NONE && types != Q_COND[5:0]) begin
                bad = 1'b1;
            end
            if ((types & ~Q_COND[5:0]) != 6'h00 && (q & Q_TAKEN) == Q_NONE) begin
                bad = 1'b1;
            end
        end
        return !bad;
    endfunction

    function automatic logic branch_match(input logic [7:0] q, input branch_status_t b);
        logic type_hit;
        logic outcome_hit;
        type_hit    = (b.kind & q[5:0]) != 6'h00;
        outcome_hit = (b.taken && (q & Q_TAKEN) != Q_NONE)
                   || (!b.taken && (q & Q_NOT_TAKEN) != Q_NONE);
        if (q == Q_ALL_BRANCHES) begin
            return b.valid;
        end
        return b.valid && type_hit && outcome_hit;
    endfunction

    // ==========================================================
    // per-cycle increment decode
    logic [INC_W-1:0] inc_nxt;
    logic             sel_valid;

    always_comb begin
        inc_nxt   = INC_ZERO;
        sel_valid = 1'b0;
        unique case (event_r)
            EVT_EXECUTED_BRANCH: begin
                sel_valid = branch_qual_ok(qual_r);
                if (sel_valid && branch_match(qual_r, core_status_i.branch)) begin
                    inc_nxt = INC_ONE;
                end
            end
            EVT_MISPREDICTED_BRANCH: begin
                sel_valid = branch_qual_ok(qual_r);
                // all-branches form counts executed branches too
                if (sel_valid && branch_match(qual_r, core_status_i.branch)
                    && (core_status_i.branch.mispredicted || qual_r == Q_ALL_BRANCHES)) begin
                    inc_nxt = INC_ONE;
                end
            end
            EVT_UNDELIVERED_UOP: begin
                sel_valid = (qual_r == Q_UNDELIVERED_CORE);
                if (sel_valid) begin
                    inc_nxt = core_status_i.undelivered_uops;
                end
            end
            EVT_PORT_DISPATCH: begin
                sel_valid = 1'b1;
                unique case (qual_r)
                    Q_PORT_0:     inc_nxt = {2'b00, core_status_i.dispatch.p0};
                    Q_PORT_1:     inc_nxt = {2'b00, core_status_i.dispatch.p1};
                    Q_PORT_2_LD:  inc_nxt = {2'b00, core_status_i.dispatch.p2_load};
                    Q_PORT_2_STA: inc_nxt = {2'b00, core_status_i.dispatch.p2_sta};
                    Q_PORT_2_ANY: inc_nxt = {2'b00, core_status_i.dispatch.p2_load
                                                  | core_status_i.dispatch.p2_sta};
                    Q_PORT_3_LD:  inc_nxt = {2'b00, core_status_i.dispatch.p3_load};
                    Q_PORT_3_STA: inc_nxt = {2'b00, core_status_i.dispatch.p3_sta};
                    Q_PORT_3_ANY: inc_nxt = {2'b00, core_status_i.dispatch.p3_load
                                                  | core_status_i.dispatch.p3_sta};
                    Q_PORT_4:     inc_nxt = {2'b00, core_status_i.dispatch.p4};
                    Q_PORT_5:     inc_nxt = {2'b00, core_status_i.dispatch.p5};
                    default: begin
                        sel_valid = 1'b0;
                        inc_nxt   = INC_ZERO;
                    end
                endcase
            end
            EVT_RESOURCE_STALL: begin
                sel_valid = 1'b1;
                unique case (qual_r)
                    Q_STALL_ANY:   inc_nxt = {2'b00, core_status_i.stall.any};
                    Q_STALL_LOAD:  inc_nxt = {2'b00, core_status_i.stall.load_buf};
                    Q_STALL_RS:    inc_nxt = {2'b00, core_status_i.stall.resv_station};
                    // sync draining also fills the store buffer but is not a shortage
                    Q_STALL_STORE: inc_nxt = {2'b00, core_status_i.stall.store_buf
                                                   & ~core_status_i.stall.store_sync_drain};
                    Q_STALL_ROB:   inc_nxt = {2'b00, core_status_i.stall.reorder_buffer};
                    Q_STALL_FPCW:  inc_nxt = {2'b00, core_status_i.stall.fp_control_word};
                    Q_STALL_SIMD:  inc_nxt = {2'b00, core_status_i.stall.simd_control_status_reg};
                    default: begin
                        sel_valid = 1'b0;
                        inc_nxt   = INC_ZERO;
                    end
                endcase
            end
            default: begin
                sel_valid = 1'b0;
                inc_nxt   = INC_ZERO;
            end
        endcase
    end

    // ==========================================================
    // increment output, one cycle behind the pipeline status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inc_r <= INC_ZERO;
        end else begin
            inc_r <= inc_nxt;
        end
    end

    assign inc_o = inc_r;

    // ==========================================================
    // running tally, restarted whenever the selection is rewritten
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tally_r <= RST_TALLY;
        end else if (sel_write) begin
            tally_r <= RST_TALLY;
        end else begin
            tally_r <= tally_r + {29'h0000_0000, inc_r};
        end
    end

    // ==========================================================
    // selection register writes, byte lanes 0 and 1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_r <= RST_EVENT;
            qual_r  <= RST_QUAL;
        end else if (sel_write) begin
            if (sel_i[0]) begin
                event_r <= dat_i[SEL_EVENT_LSB +: 8];
            end
            if (sel_i[1]) begin
                qual_r <= dat_i[SEL_QUAL_LSB +: 8];
            end
        end
    end

    // ==========================================================
    // bus answer: ack one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= access;
            if (access && !we_i) begin
                unique case (adr_i)
                    OFS_SELECT: dat_r <= {16'h0000, qual_r, event_r};
                    OFS_STATUS: dat_r <= {25'h000_0000, inc_r, 3'b000, sel_valid};
                    OFS_TALLY:  dat_r <= tally_r;
                    default:    dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

endmodule // branch_dispatch_stall_event_select

// ==== event_select_chk.sv ====
// port-level assertions for the branch, dispatch and stall event selector
`timescale 1ns/1ps

module event_select_chk
    import event_select_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0]       sel_i,
    input wire logic [31:0]      dat_i,
    input wire logic [31:0]      dat_o,
    input wire logic             ack_o,
    input wire core_status_t     core_status_i,
    input wire logic [INC_W-1:0] inc_o
);
    // ====
    // shadow of the selection, written on the edge that takes the write
    logic [7:0]     ev_r;
    logic [7:0]     q_r;
    branch_status_t br;
    assign br = core_status_i.branch;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_r <= 8'h00;
            q_r  <= 8'h00;
        end else if (cyc_i && stb_i && we_i && !ack_o && adr_i == OFS_SELECT) begin
            if (sel_i[0]) ev_r <= dat_i[7:0];
            if (sel_i[1]) q_r <= dat_i[15:8];
        end
    end

    // ====
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence wb_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence ack_pulse;
        ack_o ##1 !ack_o;
    endsequence

    AST_ACK_ONE: assert property (wb_take |=> ack_pulse)
        else $error("bus answer is not a single pulse");
    AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("acknowledge without a request");
    AST_SEL_READ: assert property (cyc_i && stb_i && !ack_o && !we_i && adr_i == OFS_SELECT |=> dat_o[15:0] == {q_r, ev_r})
        else $error("selection read back wrong");
    AST_UNDEF: assert property (!(ev_r inside {8'h88, 8'h89, 8'h9c, 8'ha1, 8'ha2}) |=> inc_o == INC_ZERO)
        else $error("undefined event gives increments");
    AST_ALL_BR: assert property (ev_r[7:1] == 7'h44 && q_r == Q_ALL_BRANCHES |=> inc_o == INC_W'($past(br.valid)))
        else $error("all-branch count wrong");
    AST_MISP_TAKEN: assert property (ev_r == 8'h89 && q_r == 8'h81 |=> inc_o == INC_W'($past(br.valid && br.kind[0] && br.taken && br.mispredicted)))
        else $error("mispredicted taken conditional count wrong");
    AST_EXEC_NT: assert property (ev_r == 8'h88 && q_r == 8'h41 |=> inc_o == INC_W'($past(br.valid && br.kind[0] && !br.taken)))
        else $error("not-taken conditional count wrong");
    AST_UNDELIV: assert property (ev_r == 8'h9c && q_r == 8'h01 |=> inc_o == $past(core_status_i.undelivered_uops))
        else $error("undelivered uop count wrong");
    AST_PORT0: assert property (ev_r == 8'ha1 && q_r == Q_PORT_0 |=> inc_o == INC_W'($past(core_status_i.dispatch.p0)))
        else $error("port 0 dispatch count wrong");
    AST_STORE: assert property (ev_r == 8'ha2 && q_r == 8'h08 |=> inc_o == INC_W'($past(core_status_i.stall.store_buf && !core_status_i.stall.store_sync_drain)))
        else $error("store buffer stall count wrong");
endmodule // event_select_chk

bind branch_dispatch_stall_event_select event_select_chk i_event_select_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .core_status_i(core_status_i),
    .inc_o(inc_o)
);

// ==== core_pipe_model.sv ====
// behavioural core pipeline status source for the event selector
`timescale 1ns/1ps

module core_pipe_model
    import event_select_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire core_status_t want_i,
    output core_status_t      core_status_o
);
    // ====
    // status launched just after an edge and held for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_status_o <= '0;
        end else begin
            core_status_o <= want_i;
            // no branch this cycle: the branch detail fields carry junk, not a stale copy
            if (!want_i.branch.valid) begin
                core_status_o.branch.kind  <= ~core_status_o.branch.kind;
                core_status_o.branch.taken <= ~core_status_o.branch.taken;
            end
        end
    end
endmodule // core_pipe_model

// ==== branch_dispatch_stall_event_select_tb.sv ====
// self-checking testbench for the branch, dispatch and stall event selector
`timescale 1ns/1ps

module branch_dispatch_stall_event_select_tb
    import event_select_pkg::*;
;
    typedef struct packed {
        logic [7:0]   ev;
        logic [7:0]   q;
        core_status_t st;
        logic [2:0]   exp;
    } row_t;

    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         cyc_i = 1'b0;
    logic         stb_i = 1'b0;
    logic         we_i  = 1'b0;
    logic [3:0]   adr_i = 4'h0;
    logic [3:0]   sel_i = 4'h0;
    logic [31:0]  dat_i = 32'h0;
    logic [31:0]  dat_o;
    logic         ack_o;
    logic [2:0]   inc_o;
    logic [31:0]  rd;
    core_status_t want = '0;
    core_status_t core_status_i;
    int           fail_count = 0;
    int           checked = 0;
    row_t         rows[$];
    logic [7:0]   aq[10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h30, 8'h40, 8'h80};
    logic [7:0]   sq[7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    logic [7:0]   sv[7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};

    always #20 clk_i = ~clk_i;

    core_pipe_model i_core_pipe_model (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .core_status_o(core_status_i));
    branch_dispatch_stall_event_select i_branch_dispatch_stall_event_select (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .core_status_i(core_status_i),
        .inc_o(inc_o));

    // ====
    // helpers
    function automatic core_status_t brs(logic [5:0] k, int t, int m);
        brs = '0;
        brs.branch = {1'b1, k, t[0], m[0]};
    endfunction
    function automatic core_status_t stat(logic [7:0] d, logic [7:0] s, logic [2:0] u);
        stat = '0;
        stat.dispatch = d;
        stat.stall = s;
        stat.undelivered_uops = u;
    endfunction
    // qualifier bit 0 is the most significant dispatch field
    function automatic logic [7:0] rev(logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7-i];
    endfunction
    function automatic row_t mk(logic [7:0] e, logic [7:0] q, core_status_t s, logic [2:0] x);
        mk = '{e, q, s, x};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        while (ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50) check("bus answer", 32'h1, 32'h0);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        complete_run();
    end

    // ====
    // main sequence
    initial begin
        rows.push_back(mk(8'h88, 8'h90, brs(6'h10, 1, 0), 3'h1));
        rows.push_back(mk(8'h88, 8'h90, brs(6'h02, 1, 0), 3'h0));
        rows.push_back(mk(8'h88, 8'ha0, brs(6'h20, 1, 0), 3'h1));
        rows.push_back(mk(8'h88, 8'h41, brs(6'h01, 0, 0), 3'h1));
        rows.push_back(mk(8'h88, 8'h41, brs(6'h01, 1, 0), 3'h0));
        rows.push_back(mk(8'h88, 8'h86, brs(6'h04, 1, 0), 3'h1));
        rows.push_back(mk(8'h88, 8'h86, brs(6'h04, 0, 0), 3'h0));
        rows.push_back(mk(8'h88, 8'hff, brs(6'h08, 0, 0), 3'h1));
        rows.push_back(mk(8'h89, 8'hff, brs(6'h01, 1, 0), 3'h1));
        rows.push_back(mk(8'h89, 8'h81, brs(6'h01, 1, 1), 3'h1));
        rows.push_back(mk(8'h89, 8'h81, brs(6'h01, 1, 0), 3'h0));
        rows.push_back(mk(8'h89, 8'h8c, brs(6'h08, 1, 1), 3'h1));
        rows.push_back(mk(8'h89, 8'h84, brs(6'h08, 1, 1), 3'h0));
        rows.push_back(mk(8'h89, 8'hb0, brs(6'h20, 1, 1), 3'h1));
        rows.push_back(mk(8'h89, 8'h41, brs(6'h01, 0, 1), 3'h1));
        rows.push_back(mk(8'h89, 8'h80, brs(6'h01, 1, 1), 3'h0));
        rows.push_back(mk(8'h88, 8'h10, brs(6'h10, 1, 0), 3'h0));
        rows.push_back(mk(8'h88, 8'h44, brs(6'h04, 0, 0), 3'h0));
        rows.push_back(mk(8'h8a, 8'hff, brs(6'h01, 1, 1), 3'h0));
        rows.push_back(mk(8'h9c, 8'h01, stat(8'h00, 8'h00, 3'h5), 3'h5));
        rows.push_back(mk(8'h9c, 8'h01, stat(8'h00, 8'h00, 3'h7), 3'h7));
        for (int i = 0; i < 10; i++) begin
            rows.push_back(mk(8'ha1, aq[i], stat(rev(aq[i]), 8'h00, 3'h0), 3'h1));
            rows.push_back(mk(8'ha1, aq[i], stat(~rev(aq[i]), 8'h00, 3'h0), 3'h0));
        end
        rows.push_back(mk(8'ha1, 8'h0c, stat(8'h10, 8'h00, 3'h0), 3'h1));
        rows.push_back(mk(8'ha1, 8'h30, stat(8'h08, 8'h00, 3'h0), 3'h1));
        rows.push_back(mk(8'ha1, 8'h03, stat(8'hff, 8'h00, 3'h0), 3'h0));
        for (int i = 0; i < 7; i++) begin
            rows.push_back(mk(8'ha2, sq[i], stat(8'h00, sv[i], 3'h0), 3'h1));
            rows.push_back(mk(8'ha2, sq[i], stat(8'h00, ~sv[i], 3'h0), 3'h0));
        end
        rows.push_back(mk(8'ha2, 8'h08, stat(8'h00, 8'h18, 3'h0), 3'h0));
        rows.push_back(mk(8'ha2, 8'h80, stat(8'h00, 8'hff, 3'h0), 3'h0));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, OFS_SELECT, 32'h0);
        check("select after reset", 32'h0, rd);
        foreach (rows[i]) begin
            wb(1'b1, OFS_SELECT, {16'h0, rows[i].q, rows[i].ev});
            want <= rows[i].st;
            repeat (2) @(posedge clk_i);
            #1;
            check($sformatf("inc row %0d", i), {29'h0, rows[i].exp}, {29'h0, inc_o});
        end
        wb(1'b0, 4'hc, 32'h0);
        check("unmapped read", 32'h0, rd);
        wb(1'b0, OFS_SELECT, 32'h0);
        check("select read back", 32'h0000_80a2, rd);
        wb(1'b1, OFS_SELECT, 32'h0000_1088);
        wb(1'b0, OFS_STATUS, 32'h0);
        check("valid flag, call without taken", 32'h0, {31'h0, rd[0]});
        // a second reset mid-run must drop the selection while status keeps flowing
        want <= stat(8'hff, 8'hff, 3'h6);
        wb(1'b1, OFS_SELECT, 32'h0000_019c);
        // tally cleared by the write, then one cycle of 6 lands before the read is taken
        wb(1'b0, OFS_TALLY, 32'h0);
        check("tally after select", 32'h6, rd);
        wb(1'b0, OFS_STATUS, 32'h0);
        check("status inc and valid", 32'h61, rd);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        check("inc after second reset", 32'h0, {29'h0, inc_o});
        wb(1'b0, OFS_SELECT, 32'h0);
        check("select after second reset", 32'h0, rd);
        wb(1'b0, OFS_TALLY, 32'h0);
        check("tally after second reset", 32'h0, rd);
        complete_run();
    end
endmodule // branch_dispatch_stall_event_select_tb
